// ### logic/tpm_pkg.sv
// package: register map, field layouts and timing for the test port block
`default_nettype none
package tpm_pkg;

  localparam int unsigned ADDR_W = 8;

  localparam logic [7:0] OFF_TEST_SELECT     = 8'h00;
  localparam logic [7:0] OFF_STRENGTH        = 8'h04;
  localparam logic [7:0] OFF_ED_THRESH       = 8'h08;
  localparam logic [7:0] OFF_SQ1_THRESH      = 8'h0C;
  localparam logic [7:0] OFF_SQ2_THRESH      = 8'h10;
  localparam logic [7:0] OFF_STATUS          = 8'h14;

  localparam int unsigned MODE_W = 4;
  localparam logic [3:0] MODE_LAST = 4'h8;
  localparam logic [3:0] RST_TEST_SELECT = 4'h0;
  localparam logic [5:0] RST_ED_THRESH   = 6'h20;
  localparam logic [7:0] RST_SQ_THRESH   = 8'h80;

  localparam int unsigned ST_ED   = 0;
  localparam int unsigned ST_CRS  = 1;
  localparam int unsigned ST_IDET = 2;
  localparam int unsigned ST_RXON = 3;
  localparam int unsigned ST_TXON = 4;
  localparam int unsigned ST_SLP  = 5;

  localparam int unsigned CLK_MHZ       = 10;
  localparam int unsigned WAKE_SLEEP_NS = 10000;
  localparam int unsigned WAKE_RX_NS    = 1000;
  localparam int unsigned WAKE_TX_MCLK  = 2;
  localparam int unsigned WAKE_SLEEP_CYC = WAKE_SLEEP_NS * CLK_MHZ / 1000;
  localparam int unsigned WAKE_RX_CYC    = WAKE_RX_NS * CLK_MHZ / 1000;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    TM_NORMAL, TM_CORR, TM_FREQ, TM_PHASE, TM_NCO,
    TM_PHVAR, TM_SYNC1, TM_SYNC2, TM_REFADJ
  } tpm_mode_type;

  typedef enum {RX_OFF, RX_WAKE, RX_ON, RX_SLEEP} tpm_rx_type;

  // internal observables offered to the port
  typedef struct packed {
    logic [7:0]  correlator_magnitude;
    logic [7:0]  oscillator_frequency_value;
    logic [7:0]  corrected_phase;
    logic [7:0]  oscillator_phase_accumulator;
    logic [7:0]  sync_accumulator_value;
    logic [15:0] sync_quality_raw;
    logic [15:0] phase_variance_raw;
    logic [4:0]  ref_adjust_code;
    logic        pn_acquired;
  } tpm_probe_type;

  typedef struct packed {
    logic transmit_chip_clock;
    logic symbol_clock;
    logic receive_sample_clock;
    logic quality_sample_strobe;
    logic ref_adjust_clock;
  } tpm_strobe_type;

endpackage : tpm_pkg
`default_nettype wire

// ### logic/tpm_test_port.sv
// test port multiplexer, strength sampling and power control
// How it works
// - strength result held in 8-bit register per symbol
// - energy_detect when strength above threshold
// - nine modes, codes 9-15 reserved
// - mode 0 flags with transmit chip clock
// - modes 1-4 correlator, frequency, phase, accumulator
// - modes 5-7 quality slices and sync mantissa
// - mode 8 flags plus ref_adjust_code
// - dedicated strobe accompanies test data
// - initial_detect needs both qualities above thresholds
// - carrier_sense once pn acquisition achieved
// - sync quality stored 16-bit, bits 14:7 shown
// - phase variance stored 16-bit, top 8 shown
// - calibration output high on full scale sample
// - receiver, transmitter off while enables inactive
// - awake within 10 us after sleep
// - receiver active within 1 us
// - transmitter active within two clocks
// - configuration kept through power down
// - device reset leaves configuration untouched
`timescale 1ns/1ps
`default_nettype none
module tpm_test_port #(
  parameter int unsigned WAKE_SLEEP_CYC = tpm_pkg::WAKE_SLEEP_CYC,
  parameter int unsigned WAKE_RX_CYC    = tpm_pkg::WAKE_RX_CYC
) (
  input  wire logic                   sys_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   device_reset_i,
  input  wire logic                   receive_power_enable_i,
  input  wire logic                   transmit_power_enable_i,
  input  wire logic [5:0]             received_strength_i,
  input  wire logic                   i_full_scale_i,
  input  wire logic                   q_full_scale_i,
  input  wire tpm_pkg::tpm_probe_type probe_i,
  input  wire tpm_pkg::tpm_strobe_type strobe_i,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic [7:0]                  test_data_o,
  output logic                        test_strobe_out_o,
  output logic                        carrier_sense_o,
  output logic                        energy_detect_o,
  output logic                        initial_detect_o,
  output logic                        cal_level_o,
  output logic                        receiver_enable_o,
  output logic                        transmitter_enable_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [3:0]  test_select_r;
    logic [5:0]  ed_thresh_r;
    logic [7:0]  sq1_thresh_r;
    logic [7:0]  sq2_thresh_r;
    logic [7:0]  strength_r;
    logic        sym_d_r;
    logic        ed_r;
    logic        crs_r;
    logic        idet_r;
    logic        cal_r;
    logic [7:0]  test_data_r;
    logic        strobe_r;
    logic [1:0]  rx_st_r;
    logic [15:0] wait_r;
    logic        rx_on_r;
    logic [1:0]  tx_cnt_r;
    logic        tx_on_r;
    logic        aw_got_r;
    logic        w_got_r;
    logic [7:0]  aw_addr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        bvalid_r;
    logic [1:0]  bresp_r;
    logic        rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0]  rresp_r;
  } tpm_state_type;

  tpm_state_type s_r;
  tpm_state_type s_nxt;
  tpm_pkg::tpm_rx_type rx_st;
  logic [7:0] sq1_top;
  logic [7:0] sq2_top;
  logic       wr_go;
  logic       rd_go;
  logic       wake_sleep_done;
  logic       wake_rx_done;

  logic       sym_rise;
  logic       ed_over;
  logic       sq1_over;
  logic       sq2_over;
  logic       fs_any;
  logic       tx_ask;
  logic       aw_take;
  logic       w_take;
  logic       wr_done;
  logic       rd_done;

  assign rx_st   = tpm_pkg::tpm_rx_type'(s_r.rx_st_r);
  assign sq1_top = probe_i.sync_quality_raw[15:8];
  assign sq2_top = probe_i.phase_variance_raw[15:8];
  assign wr_go   = s_r.aw_got_r && s_r.w_got_r && !s_r.bvalid_r;
  assign rd_go   = s_axi_arvalid && !s_r.rvalid_r;
  assign wake_sleep_done = s_r.wait_r >= 16'(WAKE_SLEEP_CYC - 1);
  assign wake_rx_done    = s_r.wait_r >= 16'(WAKE_RX_CYC - 1);

  assign sym_rise = strobe_i.symbol_clock && !s_r.sym_d_r;
  assign ed_over  = s_r.strength_r[5:0] > s_r.ed_thresh_r;
  assign sq1_over = sq1_top > s_r.sq1_thresh_r;
  assign sq2_over = sq2_top > s_r.sq2_thresh_r;
  assign fs_any   = i_full_scale_i || q_full_scale_i;
  assign tx_ask   = transmit_power_enable_i && !device_reset_i;
  assign aw_take  = s_axi_awvalid && !s_r.aw_got_r;
  assign w_take   = s_axi_wvalid && !s_r.w_got_r;
  assign wr_done  = s_r.bvalid_r && s_axi_bready;
  assign rd_done  = s_r.rvalid_r && s_axi_rready;

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_nxt = s_r;
    // flags
    s_nxt.sym_d_r = strobe_i.symbol_clock;
    if (sym_rise) begin
      s_nxt.strength_r = {2'b00, received_strength_i};
    end
    s_nxt.ed_r   = s_r.rx_on_r && ed_over;
    s_nxt.crs_r  = s_r.rx_on_r && probe_i.pn_acquired;
    s_nxt.idet_r = s_r.rx_on_r && sq1_over && sq2_over;
    s_nxt.cal_r  = s_r.rx_on_r && fs_any;

    // test port mux
    case (s_r.test_select_r)
      tpm_pkg::TM_NORMAL: begin
        s_nxt.test_data_r = {s_r.crs_r, s_r.ed_r, 3'b000, s_r.idet_r,
                             2'b00};
        s_nxt.strobe_r = strobe_i.transmit_chip_clock;
      end
      tpm_pkg::TM_CORR: begin
        s_nxt.test_data_r = probe_i.correlator_magnitude;
        s_nxt.strobe_r = strobe_i.transmit_chip_clock;
      end
      tpm_pkg::TM_FREQ: begin
        s_nxt.test_data_r = probe_i.oscillator_frequency_value;
        s_nxt.strobe_r = strobe_i.symbol_clock;
      end
      tpm_pkg::TM_PHASE: begin
        s_nxt.test_data_r = probe_i.corrected_phase;
        s_nxt.strobe_r = strobe_i.symbol_clock;
      end
      tpm_pkg::TM_NCO: begin
        s_nxt.test_data_r = probe_i.oscillator_phase_accumulator;
        s_nxt.strobe_r = strobe_i.symbol_clock;
      end
      tpm_pkg::TM_PHVAR: begin
        s_nxt.test_data_r = probe_i.phase_variance_raw[15:8];
        s_nxt.strobe_r = strobe_i.quality_sample_strobe;
      end
      tpm_pkg::TM_SYNC1: begin
        s_nxt.test_data_r = probe_i.sync_accumulator_value;
        s_nxt.strobe_r = strobe_i.receive_sample_clock;
      end
      tpm_pkg::TM_SYNC2: begin
        s_nxt.test_data_r = probe_i.sync_quality_raw[14:7];
        s_nxt.strobe_r = strobe_i.quality_sample_strobe;
      end
      tpm_pkg::TM_REFADJ: begin
        s_nxt.test_data_r = {s_r.crs_r, s_r.ed_r, 1'b0,
                             probe_i.ref_adjust_code};
        s_nxt.strobe_r = strobe_i.ref_adjust_clock;
      end
      default: begin
        s_nxt.test_data_r = 8'h00;
        s_nxt.strobe_r = 1'b0;
      end
    endcase

    // receiver power sequencing
    s_nxt.wait_r = s_r.wait_r + 16'h0001;
    case (rx_st)
      tpm_pkg::RX_OFF: begin
        s_nxt.rx_on_r = 1'b0;
        s_nxt.wait_r = 16'h0000;
        if (device_reset_i) begin
          s_nxt.rx_st_r = 2'(tpm_pkg::RX_SLEEP);
        end else if (receive_power_enable_i) begin
          s_nxt.rx_st_r = 2'(tpm_pkg::RX_WAKE);
          s_nxt.wait_r  = 16'h0001;
        end
      end
      tpm_pkg::RX_WAKE: begin
        if (!receive_power_enable_i || device_reset_i) begin
          s_nxt.rx_st_r = 2'(tpm_pkg::RX_OFF);
        end else if (wake_rx_done) begin
          s_nxt.rx_st_r = 2'(tpm_pkg::RX_ON);
          s_nxt.rx_on_r = 1'b1;
        end
      end
      tpm_pkg::RX_SLEEP: begin
        s_nxt.rx_on_r = 1'b0;
        if (device_reset_i) begin
          s_nxt.wait_r = 16'h0000;
        end else if (!receive_power_enable_i) begin
          s_nxt.wait_r = 16'h0000;
          s_nxt.rx_st_r = 2'(tpm_pkg::RX_OFF);
        end else if (wake_sleep_done) begin
          s_nxt.rx_st_r = 2'(tpm_pkg::RX_ON);
          s_nxt.rx_on_r = 1'b1;
        end
      end
      tpm_pkg::RX_ON: begin
        if (!receive_power_enable_i) begin
          s_nxt.rx_st_r = 2'(tpm_pkg::RX_OFF);
          s_nxt.rx_on_r = 1'b0;
        end
      end
      default: begin
        s_nxt.rx_st_r = 2'(tpm_pkg::RX_OFF);
      end
    endcase

    // transmitter power sequencing
    if (!tx_ask) begin
      s_nxt.tx_cnt_r = 2'b00;
      s_nxt.tx_on_r  = 1'b0;
    end else if (!s_r.tx_on_r) begin
      s_nxt.tx_cnt_r = s_r.tx_cnt_r + 2'b01;
      s_nxt.tx_on_r  = s_r.tx_cnt_r == 2'(tpm_pkg::WAKE_TX_MCLK - 1);
    end

    // write channel
    if (aw_take) begin
      s_nxt.aw_got_r  = 1'b1;
      s_nxt.aw_addr_r = s_axi_awaddr;
    end
    if (w_take) begin
      s_nxt.w_got_r = 1'b1;
      s_nxt.wdata_r = s_axi_wdata;
      s_nxt.wstrb_r = s_axi_wstrb;
    end
    if (wr_go) begin
      s_nxt.aw_got_r = 1'b0;
      s_nxt.w_got_r  = 1'b0;
      s_nxt.bvalid_r = 1'b1;
      s_nxt.bresp_r  = tpm_pkg::RESP_OKAY;
      case (s_r.aw_addr_r)
        tpm_pkg::OFF_TEST_SELECT: begin
          if (s_r.wstrb_r[0]) begin
            s_nxt.test_select_r = s_r.wdata_r[3:0];
          end
        end
        tpm_pkg::OFF_ED_THRESH: begin
          if (s_r.wstrb_r[0]) begin
            s_nxt.ed_thresh_r = s_r.wdata_r[5:0];
          end
        end
        tpm_pkg::OFF_SQ1_THRESH: begin
          if (s_r.wstrb_r[0]) begin
            s_nxt.sq1_thresh_r = s_r.wdata_r[7:0];
          end
        end
        tpm_pkg::OFF_SQ2_THRESH: begin
          if (s_r.wstrb_r[0]) begin
            s_nxt.sq2_thresh_r = s_r.wdata_r[7:0];
          end
        end
        tpm_pkg::OFF_STRENGTH, tpm_pkg::OFF_STATUS: begin
          s_nxt.bresp_r = tpm_pkg::RESP_OKAY;
        end
        default: begin
          s_nxt.bresp_r = tpm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (wr_done) begin
      s_nxt.bvalid_r = 1'b0;
    end

    // read channel
    if (rd_go) begin
      s_nxt.rvalid_r = 1'b1;
      s_nxt.rresp_r  = tpm_pkg::RESP_OKAY;
      s_nxt.rdata_r  = 32'h0000_0000;
      case (s_axi_araddr)
        tpm_pkg::OFF_TEST_SELECT: begin
          s_nxt.rdata_r[3:0] = s_r.test_select_r;
        end
        tpm_pkg::OFF_STRENGTH: begin
          s_nxt.rdata_r[7:0] = s_r.strength_r;
        end
        tpm_pkg::OFF_ED_THRESH: begin
          s_nxt.rdata_r[5:0] = s_r.ed_thresh_r;
        end
        tpm_pkg::OFF_SQ1_THRESH: begin
          s_nxt.rdata_r[7:0] = s_r.sq1_thresh_r;
        end
        tpm_pkg::OFF_SQ2_THRESH: begin
          s_nxt.rdata_r[7:0] = s_r.sq2_thresh_r;
        end
        tpm_pkg::OFF_STATUS: begin
          s_nxt.rdata_r[tpm_pkg::ST_ED]   = s_r.ed_r;
          s_nxt.rdata_r[tpm_pkg::ST_CRS]  = s_r.crs_r;
          s_nxt.rdata_r[tpm_pkg::ST_IDET] = s_r.idet_r;
          s_nxt.rdata_r[tpm_pkg::ST_RXON] = s_r.rx_on_r;
          s_nxt.rdata_r[tpm_pkg::ST_TXON] = s_r.tx_on_r;
          s_nxt.rdata_r[tpm_pkg::ST_SLP]  = rx_st == tpm_pkg::RX_SLEEP;
        end
        default: begin
          s_nxt.rresp_r = tpm_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rd_done) begin
      s_nxt.rvalid_r = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; device_reset_i never touches configuration
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.test_select_r <= tpm_pkg::RST_TEST_SELECT;
      s_r.ed_thresh_r   <= tpm_pkg::RST_ED_THRESH;
      s_r.sq1_thresh_r  <= tpm_pkg::RST_SQ_THRESH;
      s_r.sq2_thresh_r  <= tpm_pkg::RST_SQ_THRESH;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign s_axi_awready = !s_r.aw_got_r;
  assign s_axi_wready  = !s_r.w_got_r;
  assign s_axi_bvalid  = s_r.bvalid_r;
  assign s_axi_bresp   = s_r.bresp_r;
  assign s_axi_arready = !s_r.rvalid_r;
  assign s_axi_rvalid  = s_r.rvalid_r;
  assign s_axi_rdata   = s_r.rdata_r;
  assign s_axi_rresp   = s_r.rresp_r;
  assign test_data_o       = s_r.test_data_r;
  assign test_strobe_out_o = s_r.strobe_r;
  assign carrier_sense_o   = s_r.crs_r;
  assign energy_detect_o   = s_r.ed_r;
  assign initial_detect_o  = s_r.idet_r;
  assign cal_level_o       = s_r.cal_r;
  assign receiver_enable_o    = s_r.rx_on_r;
  assign transmitter_enable_o = s_r.tx_on_r;

endmodule : tpm_test_port
`default_nettype wire

// ### testbench/tpm_test_port_asserts.sv
// checker: power, wake and flag relations at the block's ports
`timescale 1ns/1ps
`default_nettype none
module tpm_test_port_asserts #(
  parameter int unsigned WAKE_SLEEP_CYC = 100
) (
  input wire logic                   sys_clk_i,
  input wire logic                   rst_i,
  input wire logic                   device_reset_i,
  input wire logic                   receive_power_enable_i,
  input wire logic                   transmit_power_enable_i,
  input wire logic                   i_full_scale_i,
  input wire logic                   q_full_scale_i,
  input wire tpm_pkg::tpm_probe_type probe_i,
  input wire logic                   carrier_sense_o,
  input wire logic                   energy_detect_o,
  input wire logic                   initial_detect_o,
  input wire logic                   cal_level_o,
  input wire logic                   receiver_enable_o,
  input wire logic                   transmitter_enable_o
);
  logic [7:0] up_r;
  // cycles with receive enable high and device reset low
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) up_r <= 8'h00;
    else if (!receive_power_enable_i || device_reset_i) up_r <= 8'h00;
    else if (up_r != 8'hFF) up_r <= up_r + 8'h01;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_tx_ask;
    transmit_power_enable_i && !device_reset_i && !rst_i;
  endsequence
  sequence s_rx_off;
    !receiver_enable_o [*2];
  endsequence
  property p_tx_wake; s_tx_ask [*3] |-> transmitter_enable_o; endproperty
  a_tx_wake: assert property (p_tx_wake) else $error("tx late");
  property p_tx_off; !transmit_power_enable_i |=> !transmitter_enable_o;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx on");
  property p_rx_off; !receive_power_enable_i |=> !receiver_enable_o;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx on");
  property p_quiet;
    s_rx_off |-> !(carrier_sense_o || energy_detect_o || initial_detect_o
      || cal_level_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("flag while off");
  property p_wake; up_r >= WAKE_SLEEP_CYC |-> receiver_enable_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake late");
  property p_crs; carrier_sense_o |-> $past(probe_i.pn_acquired); endproperty
  a_crs: assert property (p_crs) else $error("crs no pn");
  property p_idet;
    initial_detect_o |-> $past(probe_i.sync_quality_raw[15:8]) != 8'h00
      && $past(probe_i.phase_variance_raw[15:8]) != 8'h00;
  endproperty
  a_idet: assert property (p_idet) else $error("idet low q");
  property p_cal;
    receiver_enable_o && $past(receiver_enable_o)
      |-> cal_level_o == $past(i_full_scale_i || q_full_scale_i);
  endproperty
  a_cal: assert property (p_cal) else $error("cal level");
endmodule : tpm_test_port_asserts
bind tpm_test_port tpm_test_port_asserts #(
  .WAKE_SLEEP_CYC(WAKE_SLEEP_CYC)
) u_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .device_reset_i(device_reset_i),
  .receive_power_enable_i(receive_power_enable_i),
  .transmit_power_enable_i(transmit_power_enable_i),
  .i_full_scale_i(i_full_scale_i), .q_full_scale_i(q_full_scale_i),
  .probe_i(probe_i), .carrier_sense_o(carrier_sense_o),
  .energy_detect_o(energy_detect_o), .initial_detect_o(initial_detect_o),
  .cal_level_o(cal_level_o), .receiver_enable_o(receiver_enable_o),
  .transmitter_enable_o(transmitter_enable_o)
);
`default_nettype wire

// ### testbench/tpm_proc_model.sv
// model of the external processor driving power and reset pins
`timescale 1ns/1ps
`default_nettype none
module tpm_proc_model (
  input  wire logic clk_i,
  input  wire logic rx_req_i,
  input  wire logic tx_req_i,
  input  wire logic sleep_req_i,
  output var logic  receive_power_enable_o,
  output var logic  transmit_power_enable_o,
  output var logic  dev_rst_o
);
  logic [1:0] gap_r;
  initial begin
    gap_r = 2'h0;
    receive_power_enable_o = 1'b1;
    transmit_power_enable_o = 1'b1;
    dev_rst_o = 1'b0;
  end
  always @(posedge clk_i) begin
    receive_power_enable_o <= rx_req_i & ~sleep_req_i;
    transmit_power_enable_o <= tx_req_i & ~sleep_req_i;
    if (!sleep_req_i) begin
      gap_r <= 2'h0;
      dev_rst_o <= 1'b0;
    end
    else if (gap_r < 2'h2) gap_r <= gap_r + 2'h1;
    else dev_rst_o <= 1'b1;
  end
endmodule : tpm_proc_model
`default_nettype wire

// ### testbench/tb_tpm_test_port.sv
// testbench for the test port block
`timescale 1ns/1ps
`default_nettype none
module tb_tpm_test_port;
  localparam int unsigned WRX = 2;
  localparam int unsigned WSL = 4;
  localparam logic [1:0]  OK = tpm_pkg::RESP_OKAY;
  logic                   sys_clk_i = 1'b0, rst_i = 1'b1;
  logic                   rx_req = 1'b1, tx_req = 1'b1, sleep_req = 1'b0;
  logic                   receive_power_enable, transmit_power_enable, dev_rst;
  logic [5:0]             strength = 6'h00;
  logic                   i_fs = 1'b0, q_fs = 1'b0;
  tpm_pkg::tpm_probe_type probe = {8'h11, 8'h22, 8'h33, 8'h44, 8'h55,
                                   16'hA5C3, 16'hB6D9, 5'h1A, 1'b0};
  tpm_pkg::tpm_strobe_type strb = 5'h00;
  logic [7:0]             s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]            s_axi_wdata = 32'h0, s_axi_rdata;
  logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic                   s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic                   s_axi_rready = 1'b0;
  logic                   s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                   s_axi_arready, s_axi_rvalid;
  logic [1:0]             s_axi_bresp, s_axi_rresp;
  logic [7:0]             test_data;
  logic                   t_stb, carrier_sense, ed, idet, cal, rx_en, tx_en;
  int                     fails = 0, compares = 0;
  int                     sidx [9] = '{4, 4, 3, 3, 3, 1, 2, 1, 0};
  always #50 sys_clk_i = ~sys_clk_i;
  tpm_proc_model u_tpm_proc_model (.clk_i(sys_clk_i), .rx_req_i(rx_req),
    .tx_req_i(tx_req), .sleep_req_i(sleep_req), .receive_power_enable_o(receive_power_enable),
    .transmit_power_enable_o(transmit_power_enable), .dev_rst_o(dev_rst));
  tpm_test_port #(.WAKE_SLEEP_CYC(WSL), .WAKE_RX_CYC(WRX)) u_tpm_test_port (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .device_reset_i(dev_rst),
    .receive_power_enable_i(receive_power_enable), .transmit_power_enable_i(transmit_power_enable),
    .received_strength_i(strength), .i_full_scale_i(i_fs),
    .q_full_scale_i(q_fs), .probe_i(probe), .strobe_i(strb),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .test_data_o(test_data),
    .test_strobe_out_o(t_stb), .carrier_sense_o(carrier_sense), .energy_detect_o(ed),
    .initial_detect_o(idet), .cal_level_o(cal), .receiver_enable_o(rx_en),
    .transmitter_enable_o(tx_en));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wt(input int n);
    repeat (n) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask : wt
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_i);
    chk(dev_rst, 1'b0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk_i);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(OK));
    if (n == 40) fails++;
  endtask : wr
  task rchk(input logic [7:0] a, input logic [31:0] ed_v, input logic [1:0] er);
    int n;
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge sys_clk_i);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed_v);
    chk(32'(s_axi_rresp), 32'(er));
    if (n == 40) fails++;
  endtask : rchk
  task sym(input logic [5:0] s);
    @(posedge sys_clk_i);
    strength <= s;
    strb.symbol_clock <= 1'b1;
    @(posedge sys_clk_i);
    strb.symbol_clock <= 1'b0;
    wt(3);
  endtask : sym
  function automatic logic [7:0] exp_tp(input int m);
    case (m)
      0: return 8'hC4;
      1: return probe.correlator_magnitude;
      2: return probe.oscillator_frequency_value;
      3: return probe.corrected_phase;
      4: return probe.oscillator_phase_accumulator;
      5: return probe.phase_variance_raw[15:8];
      6: return probe.sync_accumulator_value;
      7: return probe.sync_quality_raw[14:7];
      8: return {3'b110, probe.ref_adjust_code};
      default: return 8'h00;
    endcase
  endfunction : exp_tp
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    rchk(tpm_pkg::OFF_TEST_SELECT, 32'(tpm_pkg::RST_TEST_SELECT), OK);
    rchk(tpm_pkg::OFF_ED_THRESH, 32'(tpm_pkg::RST_ED_THRESH), OK);
    rchk(tpm_pkg::OFF_SQ1_THRESH, 32'(tpm_pkg::RST_SQ_THRESH), OK);
    rchk(tpm_pkg::OFF_SQ2_THRESH, 32'(tpm_pkg::RST_SQ_THRESH), OK);
    rchk(8'h18, 32'h0, tpm_pkg::RESP_SLVERR);
  endtask : t_regs
  task t_flags;
    sym(6'h20);
    chk(ed, 1'b0);
    rchk(tpm_pkg::OFF_STRENGTH, 32'h20, OK);
    wr(tpm_pkg::OFF_STRENGTH, 32'hFF);
    rchk(tpm_pkg::OFF_STRENGTH, 32'h20, OK);
    sym(6'h21);
    chk(ed, 1'b1);
    chk(carrier_sense, 1'b0);
    @(posedge sys_clk_i);
    probe.pn_acquired <= 1'b1;
    probe.sync_quality_raw <= 16'h80FF;
    wt(3);
    chk(carrier_sense, 1'b1);
    chk(idet, 1'b0);
    @(posedge sys_clk_i);
    probe.sync_quality_raw <= 16'h8100;
    i_fs <= 1'b1;
    wt(3);
    chk(idet, 1'b1);
    chk(cal, 1'b1);
    @(posedge sys_clk_i);
    i_fs <= 1'b0;
    wt(3);
    chk(cal, 1'b0);
    rchk(tpm_pkg::OFF_STATUS, 32'h0000_001F, OK);
  endtask : t_flags
  task t_modes;
    for (int m = 0; m < 16; m++) begin
      wr(tpm_pkg::OFF_TEST_SELECT, 32'(m));
      rchk(tpm_pkg::OFF_TEST_SELECT, 32'(m), OK);
      @(posedge sys_clk_i);
      strb <= (m < 9) ? 5'(1 << sidx[m]) : 5'h1F;
      wt(3);
      chk(test_data, exp_tp(m));
      if (m < 9) begin
        chk(t_stb, 1'b1);
        @(posedge sys_clk_i);
        strb <= ~5'(1 << sidx[m]);
        wt(3);
        chk(t_stb, 1'b0);
      end else begin
        chk(t_stb, 1'b0);
      end
    end
  endtask : t_modes
  task t_power;
    wr(tpm_pkg::OFF_TEST_SELECT, 32'h7);
    @(posedge sys_clk_i);
    rx_req <= 1'b0;
    wt(3);
    chk({rx_en, carrier_sense}, 2'b00);
    @(posedge sys_clk_i);
    rx_req <= 1'b1;
    wt(WRX + 1);
    chk(rx_en, 1'b1);
    @(posedge sys_clk_i);
    tx_req <= 1'b0;
    wt(3);
    chk(tx_en, 1'b0);
    @(posedge sys_clk_i);
    tx_req <= 1'b1;
    wt(3);
    chk(tx_en, 1'b1);
    @(posedge sys_clk_i);
    sleep_req <= 1'b1;
    wt(6);
    chk({rx_en, tx_en}, 2'b00);
    @(posedge sys_clk_i);
    sleep_req <= 1'b0;
    wt(WSL + 1);
    chk(rx_en, 1'b1);
    rchk(tpm_pkg::OFF_TEST_SELECT, 32'h7, OK);
  endtask : t_power
  task test_done;
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (WRX + 3) @(posedge sys_clk_i);
    t_regs;
    t_flags;
    t_modes;
    t_power;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    test_done;
  end
endmodule : tb_tpm_test_port
`default_nettype wire
